// ==== verilog/hrs_top.sv ====
`timescale 1ns/1ns
// Operation
// R01 - The stack holds sixteen 15-bit entries outside program and data space.
// R02 - Call, call_via_w and interrupt vectoring push the program counter.
// R03 - Return, return_with_literal and return_from_interrupt pop into the program counter.
// R04 - Push and pop never touch pc_high_latch; only the pc and stack_index change.
// R05 - With overflow_reset_enable at 0 the stack wraps, the 17th push overwriting the first entry.
// R06 - Overflow and underflow always set overflow_flag and underflow_flag.
// R07 - top_entry_high and top_entry_low show and modify the entry picked by stack_index.
// R08 - Writing stack_index moves the top-entry window to the chosen entry.
// R09 - stack_index is five bits wide so that overflow and underflow can be seen.
// R10 - Push increments then writes; pop reads then decrements.
// R11 - Empty is 0x1F; first push gives 0x00 and a pop from there gives 0x1F.
// R12 - With overflow_reset_enable at 1 overflow or underflow requests a device reset and records the cause.
// R13 - Overflow is a push at index 15; underflow is a pop at the empty value.
module hrs_top
  import hrs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic [14:0] pc_in,
  output logic [14:0] pc_out,
  output logic pc_load,
  output logic stack_reset_req,
  output logic [1:0] power_control_status,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // One-hot register select, shared by the write and read paths
  function automatic logic [5:0] reg_sel(input logic [7:0] a);
    reg_sel[0] = (a == HRS_OFF_INDEX);
    reg_sel[1] = (a == HRS_OFF_TOP_LOW);
    reg_sel[2] = (a == HRS_OFF_TOP_HIGH);
    reg_sel[3] = (a == HRS_OFF_STATUS);
    reg_sel[4] = (a == HRS_OFF_MASK);
    reg_sel[5] = (a == HRS_OFF_CONFIG);
  endfunction : reg_sel

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = |reg_sel(a);
  endfunction : known_addr

  logic [4:0] stack_index_r; // R09
  logic [1:0] status_r;
  logic [1:0] mask_r;
  logic cfg_r;
  logic [14:0] pc_out_r;
  logic pc_load_r;
  logic reset_req_r;
  logic [1:0] power_control_status_r;
  logic irq_r;
  logic [14:0] top_data;

  // Write channel capture
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire aw_take = s_axi_awvalid && !aw_held_r && !bvalid_r;
  wire w_take = s_axi_wvalid && !w_held_r && !bvalid_r;
  // Stack-side write waits out a push or pop; a sequencer busy every cycle stalls it
  wire [5:0] wr_sel = reg_sel(aw_addr_r);
  wire stack_op = push_req || pop_req;
  wire wr_stack = wr_sel[0] || wr_sel[1] || wr_sel[2];
  wire wr_fire = aw_held_r && w_held_r && !bvalid_r && !(stack_op && wr_stack);
  wire ar_take = s_axi_arvalid && !rvalid_r;
  wire wr_ok = known_addr(aw_addr_r);
  wire rd_ok = known_addr(s_axi_araddr);
  wire sw_idx_wr = wr_fire && (aw_addr_r == HRS_OFF_INDEX) && w_strb_r[0];
  wire sw_lo_wr = wr_fire && (aw_addr_r == HRS_OFF_TOP_LOW) && w_strb_r[0];
  wire sw_hi_wr = wr_fire && (aw_addr_r == HRS_OFF_TOP_HIGH) && w_strb_r[0];
  wire status_rd = ar_take && (s_axi_araddr == HRS_OFF_STATUS);
  wire mask_wr = wr_fire && w_strb_r[0] && wr_sel[4];
  wire cfg_wr = wr_fire && w_strb_r[0] && wr_sel[5];

  // Push wins if both asked; the sequencer never issues both
  wire op_push = push_req; // R02
  wire op_pop = pop_req && !push_req; // R03
  wire is_ovf = op_push && (stack_index_r == HRS_IDX_LAST); // R13
  wire is_unf = op_pop && (stack_index_r == HRS_IDX_EMPTY); // R13
  wire [4:0] idx_inc = (stack_index_r == HRS_IDX_LAST) ? 5'h00 : 5'(stack_index_r + 5'h01); // R05 R11
  wire [4:0] idx_dec = (stack_index_r == 5'h00) ? HRS_IDX_EMPTY :
                       (stack_index_r == HRS_IDX_EMPTY) ? HRS_IDX_LAST : 5'(stack_index_r - 5'h01); // R11
  wire halt_op = cfg_r && (is_ovf || is_unf); // R12

  // Entry write: push uses incremented index, software writes current one
  wire push_wr = op_push && !halt_op;
  wire [3:0] mem_widx = push_wr ? idx_inc[3:0] : stack_index_r[3:0]; // R10
  wire sw_top_wr = (sw_lo_wr || sw_hi_wr) && (stack_index_r != HRS_IDX_EMPTY);
  wire [14:0] sw_top_val = sw_lo_wr ? {top_data[14:8], w_data_r[7:0]} : {w_data_r[6:0], top_data[7:0]}; // R07
  wire mem_we = push_wr || sw_top_wr;
  wire [14:0] mem_wdata = push_wr ? pc_in : sw_top_val; // R04

  hrs_store u_store (
    .clk(clk),
    .wr_en(mem_we),
    .wr_idx(mem_widx),
    .wr_data(mem_wdata),
    .rd_idx(stack_index_r[3:0]), // R08
    .rd_data(top_data)
  );

  wire [4:0] idx_nxt = push_wr ? idx_inc :
                       (op_pop && !halt_op) ? idx_dec :
                       sw_idx_wr ? w_data_r[4:0] : stack_index_r; // R10 R08
  logic [1:0] ev;
  assign ev[HRS_BIT_OVF] = is_ovf; // R06
  assign ev[HRS_BIT_UNF] = is_unf; // R06
  wire [1:0] status_nxt = (status_rd ? 2'h0 : status_r) | ev; // R06
  wire [31:0] rd_mux =
    (s_axi_araddr == HRS_OFF_INDEX) ? {27'h0, stack_index_r} :
    (s_axi_araddr == HRS_OFF_TOP_LOW) ? {24'h0, top_data[7:0]} :
    (s_axi_araddr == HRS_OFF_TOP_HIGH) ? {25'h0, top_data[14:8]} :
    (s_axi_araddr == HRS_OFF_STATUS) ? {30'h0, status_r} :
    (s_axi_araddr == HRS_OFF_MASK) ? {30'h0, mask_r} :
    (s_axi_araddr == HRS_OFF_CONFIG) ? {31'h0, cfg_r} : 32'h0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack_index_r <= HRS_IDX_EMPTY; // R11
      status_r <= 2'h0;
      pc_out_r <= 15'h0;
      pc_load_r <= 1'b0;
      reset_req_r <= 1'b0;
      power_control_status_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      stack_index_r <= idx_nxt;
      status_r <= status_nxt; // R06
      pc_out_r <= top_data; // R10
      pc_load_r <= op_pop && !halt_op; // R03
      reset_req_r <= halt_op; // R12
      // Cause stays recorded until the next cause or until rstn clears it
      if (halt_op) begin
        power_control_status_r <= ev; // R12
      end
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // Config and mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_r <= HRS_MASK_RESET;
      cfg_r <= HRS_CFG_RESET;
    end else begin
      if (mask_wr) begin
        mask_r <= w_data_r[1:0];
      end
      if (cfg_wr) begin
        cfg_r <= w_data_r[HRS_BIT_CFG_RST];
      end
    end
  end

  // Write address and data may arrive in either order
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= HRS_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? HRS_RESP_OKAY : HRS_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= HRS_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_ok ? HRS_RESP_OKAY : HRS_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Ready pulses for one cycle after each capture, registered for clean outputs
  logic awready_r;
  logic wready_r;
  logic arready_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      if (aw_take) begin
        awready_r <= 1'b1;
      end
      if (w_take) begin
        wready_r <= 1'b1;
      end
      if (ar_take) begin
        arready_r <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_arready = arready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pc_out = pc_out_r;
  assign pc_load = pc_load_r;
  assign stack_reset_req = reset_req_r;
  assign power_control_status = power_control_status_r;
  assign irq = irq_r;
endmodule : hrs_top

// ==== inc/hrs_pkg.sv ====
package hrs_pkg;
  localparam int HRS_DEPTH = 16;
  localparam int HRS_WIDTH = 15;
  localparam int HRS_IDX_W = 5;
  localparam logic [4:0] HRS_IDX_EMPTY = 5'h1F;
  localparam logic [4:0] HRS_IDX_LAST = 5'h0F;
  // Register byte addresses
  localparam logic [7:0] HRS_OFF_INDEX = 8'h00;
  localparam logic [7:0] HRS_OFF_TOP_LOW = 8'h04;
  localparam logic [7:0] HRS_OFF_TOP_HIGH = 8'h08;
  localparam logic [7:0] HRS_OFF_STATUS = 8'h0C;
  localparam logic [7:0] HRS_OFF_MASK = 8'h10;
  localparam logic [7:0] HRS_OFF_CONFIG = 8'h14;
  // Status, mask and config bit positions
  localparam int HRS_BIT_OVF = 0;
  localparam int HRS_BIT_UNF = 1;
  localparam int HRS_BIT_CFG_RST = 0;
  localparam logic [1:0] HRS_MASK_RESET = 2'h0;
  localparam logic HRS_CFG_RESET = 1'h0;
  localparam logic [1:0] HRS_RESP_OKAY = 2'h0;
  localparam logic [1:0] HRS_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    HRS_OP_NONE = 2'h0,
    HRS_OP_PUSH = 2'h1,
    HRS_OP_POP = 2'h2
  } hrs_op_type;
endpackage : hrs_pkg

// ==== verilog/hrs_store.sv ====
`timescale 1ns/1ns
module hrs_store
  import hrs_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [14:0] wr_data,
  input wire logic [3:0] rd_idx,
  output logic [14:0] rd_data
);
  // Kept apart from program and data space; contents survive reset
  logic [14:0] mem [HRS_DEPTH]; // R01
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end
  assign rd_data = mem[rd_idx];
endmodule : hrs_store

// ==== bench/hrs_top_props.sv ====
`timescale 1ns/1ns
module hrs_top_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic [14:0] pc_in,
  input wire logic [14:0] pc_out,
  input wire logic pc_load,
  input wire logic stack_reset_req,
  input wire logic [1:0] power_control_status,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  pop_load_a: assert property (pop_req && !push_req |=> pc_load || stack_reset_req)
    else $error("pop gave no load");
  no_load_a: assert property (!pop_req || push_req |=> !pc_load)
    else $error("load without pop");
  pop_value_a: assert property (push_req ##1 (pop_req && !push_req && !stack_reset_req)
    |=> pc_out == $past(pc_in, 2)) else $error("popped value wrong");
  req_cause_a: assert property (stack_reset_req |-> $past(push_req) || $past(pop_req))
    else $error("reset request without op");
  cause_kept_a: assert property (!stack_reset_req |-> $stable(power_control_status))
    else $error("cause changed");
  cause_set_a: assert property (stack_reset_req |-> power_control_status != 2'h0)
    else $error("cause not recorded");
  read_ans_a: assert property (s_axi_arready |-> s_axi_rvalid) else $error("read answer late");
  write_end_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  aw_cause_a: assert property (s_axi_awready |-> $past(s_axi_awvalid)) else $error("awready unasked");
endmodule : hrs_top_props
bind hrs_top hrs_top_props u_props (.*);

// ==== bench/hrs_seq.sv ====
`timescale 1ns/1ns
module hrs_seq (
  input wire logic clk,
  input wire logic rstn,
  input wire logic call,
  input wire logic ret,
  input wire logic [14:0] target,
  output logic push_req,
  output logic pop_req,
  output logic [14:0] pc_in
);
  // Pc bus inverts between calls so a stale value never passes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      push_req <= 1'b0;
      pop_req <= 1'b0;
      pc_in <= 15'h0000;
    end else begin
      push_req <= call;
      pop_req <= ret && !call;
      pc_in <= call ? target : ~pc_in;
    end
  end
endmodule : hrs_seq

// ==== bench/hrs_top_tb.sv ====
`timescale 1ns/1ns
module hrs_top_tb;
  import hrs_pkg::*;
  logic clk, rstn, call, ret, push_req, pop_req, pc_load, stack_reset_req, irq;
  logic [14:0] target, pc_in, pc_out;
  logic [1:0] power_control_status, s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] exp_q[$];
  logic [14:0] v[0:16];
  int fail_count, n_compared, seed, n_rst;
  hrs_seq u_seq (.*);
  hrs_top dut (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task cmp(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task test_done;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task op(input logic c, input logic r, input logic [14:0] t);
    @(posedge clk);
    call <= c;
    ret <= r;
    target <= t;
    @(posedge clk);
    call <= 1'b0;
    ret <= 1'b0;
  endtask : op
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    exp_q.push_back(34'(HRS_RESP_OKAY));
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  // Every load and bus answer needs its note; an empty queue yields an unknown
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp(34'(s_axi_bresp), exp_q.pop_front());
    if (pc_load) cmp({19'h0, pc_out}, exp_q.pop_front());
    if (stack_reset_req) n_rst++;
  end
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
  initial begin
    {call, ret, target, s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, rstn} = '0;
    s_axi_wstrb = 4'hF;
    seed = 10446;
    for (int i = 0; i < 17; i++) v[i] = 15'($random(seed));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(HRS_OFF_INDEX, 34'h1F);
    rd(HRS_OFF_CONFIG, 34'h0);
    rd(8'h18, {HRS_RESP_SLVERR, 32'h0});
    op(1'b1, 1'b0, v[0]);
    rd(HRS_OFF_INDEX, 34'h0);
    rd(HRS_OFF_TOP_LOW, 34'(v[0][7:0]));
    rd(HRS_OFF_TOP_HIGH, 34'(v[0][14:8]));
    exp_q.push_back(34'(v[0]));
    op(1'b0, 1'b1, 15'h0);
    @(posedge clk);
    exp_q.push_back(34'(v[1]));
    call <= 1'b1;
    target <= v[1];
    @(posedge clk);
    call <= 1'b0;
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    rd(HRS_OFF_INDEX, 34'h1F);
    $display("test basic done");
    wr(HRS_OFF_MASK, 32'h1);
    for (int i = 0; i < 17; i++) op(1'b1, 1'b0, v[i]);
    settle();
    cmp(34'(irq), 34'h1);
    rd(HRS_OFF_INDEX, 34'h0);
    rd(HRS_OFF_STATUS, 34'h1);
    settle();
    cmp(34'(irq), 34'h0);
    rd(HRS_OFF_TOP_LOW, 34'(v[16][7:0]));
    wr(HRS_OFF_INDEX, 32'h0F);
    rd(HRS_OFF_TOP_LOW, 34'(v[15][7:0]));
    exp_q.push_back(34'(v[15]));
    op(1'b0, 1'b1, 15'h0);
    wr(HRS_OFF_TOP_LOW, 32'h5A);
    exp_q.push_back(34'({v[14][14:8], 8'h5A}));
    op(1'b0, 1'b1, 15'h0);
    settle();
    $display("test wrap done");
    rstn <= 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    wr(HRS_OFF_CONFIG, 32'h1);
    op(1'b0, 1'b1, 15'h0);
    settle();
    cmp(34'(power_control_status), 34'h2);
    cmp(34'(n_rst), 34'h1);
    rd(HRS_OFF_INDEX, 34'h1F);
    rd(HRS_OFF_STATUS, 34'h2);
    for (int i = 0; i < 17; i++) op(1'b1, 1'b0, v[i]);
    settle();
    cmp(34'(power_control_status), 34'h1);
    cmp(34'(irq), 34'h0);
    rd(HRS_OFF_INDEX, 34'h0F);
    rd(HRS_OFF_TOP_LOW, 34'(v[15][7:0]));
    rd(HRS_OFF_STATUS, 34'h1);
    settle();
    cmp(34'(n_rst), 34'h2);
    cmp(34'(exp_q.size()), 34'h0);
    $display("test reset mode done");
    test_done();
  end
endmodule : hrs_top_tb
